// ---- dv/test_cond_move_mult_sub_exec.sv ----
`timescale 1ns/1ps
module test_cond_move_mult_sub_exec import cms_pkg::*;;
  logic        clock;
  logic        arst_n;
  logic [7:0]  addr;
  logic [31:0] wrData;
  logic        wrStb;
  logic        rdStb;
  logic [31:0] rdData;
  logic        trapPulse;
  cms_exc_e    trapCode;
  int          errorCnt;
  int          compares;
  int          cycles;
  logic [31:0] rv;
  logic [31:0] hv;

  cms_exec i_cms_exec (
    .clock     (clock),
    .arst_n    (arst_n),
    .addr      (addr),
    .wrData    (wrData),
    .wrStb     (wrStb),
    .rdStb     (rdStb),
    .rdData    (rdData),
    .trapPulse (trapPulse),
    .trapCode  (trapCode)
  );

  // ==========================================
  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Whole run is well under a thousand bus cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errorCnt++;
      stopTest();
    end
  end

  // ==========================================
  // Bus and compare helpers
  task automatic chkVal(input string nm, input logic [31:0] exp,
                        input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Pulse only for a trapping instruction, code as a level
  task automatic chkTrap(input cms_exc_e exp);
    compares++;
    if ({trapPulse, trapCode} !== {exp != EXC_NONE, exp}) begin
      errorCnt++;
      $display("wrong value trap expected %h seen %h",
               {exp != EXC_NONE, exp}, {trapPulse, trapCode});
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge clock);
    wrStb  <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge clock);
    rdStb <= 1'b0;
    #1;
    d = rdData;
  endtask

  task automatic issue(input logic [31:0] ins, input cms_exc_e exp);
    wr(OFF_INSTR, ins);
    chkTrap(exp);
  endtask

  task automatic setGpr(input logic [4:0] n, input logic [31:0] v);
    wr(OFF_INDEX, {27'h0, n});
    wr(OFF_GPR, v);
  endtask

  task automatic setFpr(input logic [4:0] n, input logic [31:0] h,
                        input logic [31:0] l);
    wr(OFF_INDEX, {27'h0, n});
    wr(OFF_FPRHI, h);
    wr(OFF_FPRLO, l);
  endtask

  task automatic chkFpr(input logic [4:0] n, input logic [31:0] h,
                        input logic [31:0] l);
    wr(OFF_INDEX, {27'h0, n});
    rd(OFF_FPRHI, hv);
    chkVal("fpr high", h, hv);
    rd(OFF_FPRLO, hv);
    chkVal("fpr low", l, hv);
  endtask

  function automatic logic [31:0] fms(input logic [4:0] fr, ft, fs, fd,
                                      input logic [2:0] xf);
    return {OP_FLTX, fr, ft, fs, fd, FX_SIGNED_MULT_SUBTRACT, xf};
  endfunction

  function automatic logic [31:0] fmz(input logic [4:0] fm, rt, fs, fd);
    return {OP_FLTCOP, fm, rt, fs, fd, FN_FMOVZ};
  endfunction

  // ==========================================
  // Scenarios
  task automatic testReset();
    rd(OFF_HI, rv);
    chkVal("hi", 32'h0, rv);
    rd(OFF_FLOAT_CONTROL_REGISTER, rv);
    chkVal("float_control_register", 32'h0, rv);
    rd(8'hFC, rv);
    chkVal("unmapped", 32'h0, rv);
  endtask

  // Both coprocessors start unusable
  task automatic testTraps();
    issue(fmz(FMT_S, 5'd0, 5'd2, 5'd1), EXC_CPU);
    issue({OP_SYSCOP, SUB_MT, 5'd7, 5'd3, 11'h0}, EXC_CPU);
    issue({6'h3F, 26'h0}, EXC_RI);
    rd(OFF_STAT, rv);
    chkVal("stat", 32'h2, rv);
    wr(OFF_CTRL, 32'h3);
    issue(fmz(5'h14, 5'd0, 5'd2, 5'd1), EXC_RI);
    issue(fms(5'd1, 5'd2, 5'd3, 5'd4, 3'h2), EXC_RI);
  endtask

  task automatic testIntMove();
    setGpr(5'd1, 32'h0);
    setGpr(5'd2, 32'hA5A5_0F0F);
    setGpr(5'd4, 32'h7);
    issue({OP_SPECIAL, 5'd2, 5'd1, 5'd3, 5'h0, FN_MOVE_IF_ZERO}, EXC_NONE);
    wr(OFF_INDEX, 32'h3);
    rd(OFF_GPR, rv);
    chkVal("move if zero", 32'hA5A5_0F0F, rv);
    issue({OP_SPECIAL, 5'd4, 5'd2, 5'd3, 5'h0, FN_MOVE_IF_ZERO}, EXC_NONE);
    wr(OFF_INDEX, 32'h3);
    rd(OFF_GPR, rv);
    chkVal("no move", 32'hA5A5_0F0F, rv);
  endtask

  task automatic testMulSub();
    logic [63:0] a;
    logic [63:0] acc;
    for (int i = 0; i < 2; i++) begin
      a = (i == 0) ? 64'hFFFF_FFFF_FFFF_FFFD : 64'h0000_0000_FFFF_FFFD;
      acc = 64'h0000_0001_0000_0005 - a * 64'h7;
      setGpr(5'd5, 32'hFFFF_FFFD);
      setGpr(5'd6, 32'h7);
      wr(OFF_HI, 32'h1);
      wr(OFF_LO, 32'h5);
      issue({OP_SECOND, 5'd5, 5'd6, 10'h0, (i == 0) ? FN_SIGNED_MULT_SUBTRACT : FN_UNSIGNED_MULT_SUBTRACT},
            EXC_NONE);
      rd(OFF_HI, rv);
      chkVal("acc high", acc[63:32], rv);
      rd(OFF_LO, rv);
      chkVal("acc low", acc[31:0], rv);
      wr(OFF_INDEX, 32'h5);
      rd(OFF_GPR, rv);
      chkVal("source kept", 32'hFFFF_FFFD, rv);
    end
  endtask

  task automatic testFloatMulSub();
    wr(OFF_FLOAT_CONTROL_REGISTER, 32'h0);
    setFpr(5'd1, 32'h3F80_0000, 32'h4000_0000);
    setFpr(5'd2, 32'h3F80_0000, 32'h4040_0000);
    setFpr(5'd3, 32'h3F00_0000, 32'h3F80_0000);
    setFpr(5'd4, 32'hCAFE_F00D, 32'h0);
    issue(fms(5'd3, 5'd2, 5'd1, 5'd4, XF_S), EXC_NONE);
    chkFpr(5'd4, 32'hCAFE_F00D, 32'h40A0_0000);
    issue(fms(5'd3, 5'd2, 5'd1, 5'd5, XF_PS), EXC_NONE);
    chkFpr(5'd5, 32'h3F00_0000, 32'h40A0_0000);
    rd(OFF_FLOAT_CONTROL_REGISTER, rv);
    chkVal("exact float_control_register", 32'h0, rv);
    // Low half overflows in the product, high half stays exact
    setFpr(5'd6, 32'h3F80_0000, 32'h7F7F_FFFF);
    issue(fms(5'd7, 5'd1, 5'd6, 5'd8, XF_PS), EXC_NONE);
    chkFpr(5'd8, 32'h3F80_0000, 32'h7F80_0000);
    rd(OFF_FLOAT_CONTROL_REGISTER, rv);
    chkVal("overflow float_control_register", 32'h0000_5014, rv);
    wr(OFF_FLOAT_CONTROL_REGISTER, {30'h0, RM_ZERO});
    issue(fms(5'd7, 5'd1, 5'd6, 5'd8, XF_S), EXC_NONE);
    chkFpr(5'd8, 32'h3F80_0000, 32'h7F7F_FFFF);
    rd(OFF_FLOAT_CONTROL_REGISTER, rv);
    chkVal("toward zero float_control_register", 32'h0000_5015, rv);
    issue(fms(5'd3, 5'd2, 5'd1, 5'd9, XF_D), EXC_FPE);
    chkFpr(5'd9, 32'h0, 32'h0);
    rd(OFF_FLOAT_CONTROL_REGISTER, rv);
    chkVal("trap flags", 32'h14, rv & 32'h7C);
  endtask

  // Runs after the overflow case so the float control is nonzero
  task automatic testFloatMove();
    logic [4:0] fmts [3];
    fmts = '{FMT_S, FMT_D, FMT_PS};
    setFpr(5'd10, 32'h1111_2222, 32'h3333_4444);
    for (int k = 0; k < 3; k++) begin
      issue(fmz(fmts[k], 5'd1, 5'd10, 5'(11 + k)), EXC_NONE);
      chkFpr(5'(11 + k), 32'h1111_2222, 32'h3333_4444);
      issue(fmz(fmts[k], 5'd2, 5'd10, 5'd20), EXC_NONE);
      chkFpr(5'd20, 32'h0, 32'h0);
    end
    rd(OFF_FLOAT_CONTROL_REGISTER, rv);
    chkVal("float_control_register kept", 32'h0002_0015, rv);
  endtask

  task automatic testSysMove();
    setGpr(5'd7, 32'h600D_BEEF);
    issue({OP_SYSCOP, SUB_MT, 5'd7, 5'd3, 8'h0, 3'd0}, EXC_NONE);
    wr(OFF_INDEX, 32'h18);
    rd(OFF_CP0, rv);
    chkVal("system reg", 32'h600D_BEEF, rv);
    setGpr(5'd7, 32'h1);
    issue({OP_SYSCOP, SUB_MT, 5'd7, 5'd3, 8'h0, 3'd1}, EXC_NONE);
    issue({OP_SYSCOP, SUB_MT, 5'd7, 5'd3, 8'h1, 3'd0}, EXC_RI);
    wr(OFF_INDEX, 32'h18);
    rd(OFF_CP0, rv);
    chkVal("system reg kept", 32'h600D_BEEF, rv);
  endtask

  // ==========================================
  // Verdict and main sequence
  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    arst_n   = 1'b0;
    addr     = 8'h00;
    wrData   = 32'h0;
    wrStb    = 1'b0;
    rdStb    = 1'b0;
    errorCnt = 0;
    compares = 0;
    cycles   = 0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    testReset();
    testTraps();
    testIntMove();
    testMulSub();
    testFloatMulSub();
    testFloatMove();
    testSysMove();
    stopTest();
  end
endmodule

// ---- logic/cms_exec.sv ----
`timescale 1ns/1ps
module cms_exec import cms_pkg::*; (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic      [31:0] rdData,
  output logic             trapPulse,
  output cms_exc_e         trapCode
);
  // ==========================================
  // State
  typedef struct packed {
    logic [31:0][31:0] general_register;
    logic [31:0][63:0] floating_register;
    logic [7:0][31:0]  cp0;
    logic [31:0]       hi;
    logic [31:0]       lo;
    logic [FC_W-1:0]   float_control_register;
    logic [2:0]        ctrl;
    logic [7:0]        idx;
    cms_exc_e          exc;
    logic              trap;
    logic [31:0]       rd;
  } cms_st_s;
  cms_st_s st_ff, nxt_st;

  // ==========================================
  // Float helpers, single precision only
  // Class bits: nan, inf, zero, denormal
  function automatic logic [3:0] fcls(input logic [31:0] a);
    logic top;
    top = a[30:23] == 8'hFF;
    return {top & |a[22:0], top & ~|a[22:0], ~|a[30:0],
            ~|a[30:23] & |a[22:0]};
  endfunction

  function automatic logic cp0Hit(input logic [4:0] r, input logic [2:0] s);
    return s == 3'h0 && r < CP0_NUM; // RULE21
  endfunction

  // Tiny results trap as unimplemented rather than denormalising
  function automatic logic [37:0] fround(input logic sg,
      input logic signed [10:0] e, input logic [26:0] m,
      input logic [1:0] rm);
    logic [24:0] mr;
    logic inx;
    logic up;
    logic signed [10:0] ee;
    inx = |m[2:0];
    case (rm)
      RM_NEAR: up = m[2] & (m[1] | m[0] | m[3]);
      RM_ZERO: up = 1'b0;
      RM_PINF: up = inx & ~sg;
      default: up = inx & sg;
    endcase
    mr = {1'b0, m[26:3]} + {24'h0, up};
    ee = e;
    if (mr[24]) begin
      mr = mr >> 1;
      ee = ee + 11'sh001;
    end
    if (ee >= EXP_INF) begin
      up = rm == RM_NEAR || (rm == RM_PINF && !sg) ||
           (rm == RM_MINF && sg);
      return {C_O | C_I, sg, up ? INF_MAG : MAX_MAG}; // RULE18
    end
    if (ee < 11'sh001)
      return {C_E, 32'h0};
    return {inx ? C_I : 6'h00, sg, ee[7:0], mr[22:0]};
  endfunction

  function automatic logic [37:0] fmul(input logic [31:0] a,
      input logic [31:0] b, input logic [1:0] rm);
    logic [3:0] ca;
    logic [3:0] cb;
    logic [47:0] p;
    logic signed [10:0] e;
    logic sg;
    ca = fcls(a);
    cb = fcls(b);
    sg = a[31] ^ b[31];
    if (ca[3] | cb[3])
      return {(ca[3] & a[22]) | (cb[3] & b[22]) ? C_V : 6'h00, NAN_DEF};
    if ((ca[2] & cb[1]) | (ca[1] & cb[2]))
      return {C_V, NAN_DEF};
    if (ca[2] | cb[2])
      return {6'h00, sg, INF_MAG};
    if (ca[0] | cb[0])
      return {C_E, 32'h0};
    if (ca[1] | cb[1])
      return {6'h00, sg, 31'h0};
    p = {24'h0, 1'b1, a[22:0]} * {24'h0, 1'b1, b[22:0]};
    e = $signed({3'h0, a[30:23]}) + $signed({3'h0, b[30:23]}) - BIAS;
    if (p[47])
      return fround(sg, e + 11'sh001, {p[47:22], |p[21:0]}, rm);
    return fround(sg, e, {p[46:21], |p[20:0]}, rm);
  endfunction

  function automatic logic [37:0] fadd(input logic [31:0] a,
      input logic [31:0] b, input logic [1:0] rm);
    logic [3:0] ca;
    logic [3:0] cb;
    logic [31:0] x;
    logic [31:0] y;
    logic [7:0] d;
    logic [27:0] mx;
    logic [27:0] my;
    logic [27:0] s;
    logic signed [10:0] e;
    ca = fcls(a);
    cb = fcls(b);
    if (ca[3] | cb[3])
      return {(ca[3] & a[22]) | (cb[3] & b[22]) ? C_V : 6'h00, NAN_DEF};
    if (ca[2] & cb[2] & (a[31] != b[31]))
      return {C_V, NAN_DEF};
    if (ca[2])
      return {6'h00, a};
    if (cb[2])
      return {6'h00, b};
    if (ca[0] | cb[0])
      return {C_E, 32'h0};
    if (ca[1] & cb[1])
      return {6'h00, rm == RM_MINF ? a[31] | b[31] : a[31] & b[31], 31'h0};
    if (ca[1])
      return {6'h00, b};
    if (cb[1])
      return {6'h00, a};
    {x, y} = a[30:0] < b[30:0] ? {b, a} : {a, b};
    d = x[30:23] - y[30:23];
    mx = {2'h1, x[22:0], 3'h0};
    my = {2'h1, y[22:0], 3'h0};
    // Shifted-out bits collapse into one sticky bit
    if (d > 8'd26) my = 28'h1;
    else my = (my >> d) | {27'h0, ((my >> d) << d) != my};
    s = x[31] == y[31] ? mx + my : mx - my;
    e = $signed({3'h0, x[30:23]});
    if (s == 28'h0)
      return {6'h00, rm == RM_MINF, 31'h0};
    if (s[27]) begin
      s = {1'b0, s[27:2], s[1] | s[0]};
      e = e + 11'sh001;
    end
    for (int i = 0; i < 26; i++) begin
      if (!s[26]) begin
        s = s << 1;
        e = e - 11'sh001;
      end
    end
    return fround(x[31], e, s[26:0], rm);
  endfunction

  // Two roundings on purpose: matches separate mul and sub
  function automatic logic [37:0] fmsub(input logic [31:0] s,
      input logic [31:0] t, input logic [31:0] r, input logic [1:0] rm);
    logic [37:0] m;
    logic [37:0] q;
    m = fmul(s, t, rm); // RULE15
    if (m[37]) return m;
    q = fadd(m[31:0], {~r[31], r[30:0]}, rm); // RULE14
    return {m[37:32] | q[37:32], q[31:0]};
  endfunction

  // ==========================================
  // Next state
  logic [31:0] ins;
  logic        iss;
  assign ins = wrData;
  assign iss = wrStb && addr == OFF_INSTR;

  always_comb begin
    logic [4:0]  rs;
    logic [4:0]  rt;
    logic [4:0]  rd;
    logic [4:0]  sa;
    logic [31:0] rsv;
    logic [31:0] rtv;
    logic [37:0] r0;
    logic [37:0] r1;
    logic [5:0]  cause;
    logic        cpu;
    logic        ri;
    logic        fpe;
    rs = ins[25:21];
    rt = ins[20:16];
    rd = ins[15:11];
    sa = ins[10:6];
    rsv = st_ff.general_register[rs];
    rtv = st_ff.general_register[rt];
    r0 = '0;
    r1 = '0;
    cause = '0;
    cpu = 1'b0;
    ri = 1'b0;
    fpe = 1'b0;
    nxt_st = st_ff;
    nxt_st.trap = 1'b0;
    nxt_st.rd = '0;
    if (iss) begin
      case (ins[31:26])
        OP_SPECIAL: begin
          if (ins[5:0] != FN_MOVE_IF_ZERO) ri = 1'b1;
          else if (rtv == 32'h0 && rd != 5'h0) nxt_st.general_register[rd] = rsv; // RULE1
        end
        OP_SECOND: begin
          // Only undefined functions trap, and no general register is written here
          if (ins[5:0] == FN_SIGNED_MULT_SUBTRACT)
            {nxt_st.hi, nxt_st.lo} = {st_ff.hi, st_ff.lo} -
                64'($signed(rsv) * $signed(rtv)); // RULE9 RULE10 RULE11
          else if (ins[5:0] == FN_UNSIGNED_MULT_SUBTRACT)
            {nxt_st.hi, nxt_st.lo} = {st_ff.hi, st_ff.lo} -
                64'({32'h0, rsv} * {32'h0, rtv}); // RULE12
          else ri = 1'b1;
        end
        OP_SYSCOP: begin
          if (!st_ff.ctrl[CTL_CU0]) cpu = 1'b1; // RULE22
          else if (rs != SUB_MT || ins[10:3] != 8'h00) ri = 1'b1; // RULE22
          else if (cp0Hit(rd, ins[2:0])) nxt_st.cp0[rd[2:0]] = rtv; // RULE19
        end
        OP_FLTCOP: begin
          if (!st_ff.ctrl[CTL_CU1]) cpu = 1'b1; // RULE8
          else if (ins[5:0] != FN_FMOVZ ||
                   !(rs == FMT_S || rs == FMT_D || rs == FMT_PS))
            ri = 1'b1; // RULE8
          // Whole register copied; the float status is never touched
          else if (rtv == 32'h0) nxt_st.floating_register[sa] = st_ff.floating_register[rd]; // RULE2 RULE4
          else nxt_st.floating_register[sa] = st_ff.floating_register[sa]; // RULE3
        end
        OP_FLTX: begin
          if (!st_ff.ctrl[CTL_CU1]) cpu = 1'b1;
          else if (ins[5:3] != FX_SIGNED_MULT_SUBTRACT ||
                   !(ins[2:0] == XF_S || ins[2:0] == XF_D ||
                     ins[2:0] == XF_PS)) ri = 1'b1;
          else begin
            // Double precision is left to software emulation
            if (ins[2:0] == XF_D) cause = C_E; // RULE18
            else begin
              r0 = fmsub(st_ff.floating_register[rd][31:0], st_ff.floating_register[rt][31:0],
                         st_ff.floating_register[rs][31:0], st_ff.float_control_register[1:0]);
              r1 = fmsub(st_ff.floating_register[rd][63:32], st_ff.floating_register[rt][63:32],
                         st_ff.floating_register[rs][63:32], st_ff.float_control_register[1:0]);
              if (ins[2:0] == XF_PS) cause = r0[37:32] | r1[37:32]; // RULE16
              else cause = r0[37:32];
            end
            nxt_st.float_control_register[FC_CAUSE+:6] = cause;
            fpe = |(cause & {1'b1, st_ff.float_control_register[FC_EN+:5]});
            if (!fpe) begin
              nxt_st.float_control_register[FC_FLAG+:5] = st_ff.float_control_register[FC_FLAG+:5] |
                                        cause[4:0]; // RULE17
              nxt_st.floating_register[sa] = ins[2:0] == XF_PS ? {r1[31:0], r0[31:0]} :
                               {st_ff.floating_register[sa][63:32], r0[31:0]};
            end
          end
        end
        default: ri = 1'b1;
      endcase
      nxt_st.trap = cpu | ri | fpe;
      nxt_st.exc = cpu ? EXC_CPU : ri ? EXC_RI : fpe ? EXC_FPE : EXC_NONE;
    end else if (wrStb) begin
      case (addr)
        OFF_CTRL:  nxt_st.ctrl = wrData[2:0];
        OFF_FLOAT_CONTROL_REGISTER:  nxt_st.float_control_register = wrData[FC_W-1:0];
        OFF_HI:    nxt_st.hi = wrData;
        OFF_LO:    nxt_st.lo = wrData;
        OFF_INDEX: nxt_st.idx = wrData[7:0];
        OFF_GPR:   if (st_ff.idx[4:0] != 5'h0)
                     nxt_st.general_register[st_ff.idx[4:0]] = wrData;
        OFF_FPRLO: nxt_st.floating_register[st_ff.idx[4:0]][31:0] = wrData;
        OFF_FPRHI: nxt_st.floating_register[st_ff.idx[4:0]][63:32] = wrData;
        OFF_CP0:   if (cp0Hit(st_ff.idx[7:3], st_ff.idx[2:0]))
                     nxt_st.cp0[st_ff.idx[5:3]] = wrData;
        default:   nxt_st.rd = '0;
      endcase
    end
    if (rdStb) begin
      case (addr)
        OFF_CTRL:  nxt_st.rd = {29'h0, st_ff.ctrl};
        OFF_FLOAT_CONTROL_REGISTER:  nxt_st.rd = {14'h0, st_ff.float_control_register};
        OFF_HI:    nxt_st.rd = st_ff.hi;
        OFF_LO:    nxt_st.rd = st_ff.lo;
        OFF_INDEX: nxt_st.rd = {24'h0, st_ff.idx};
        OFF_GPR:   nxt_st.rd = st_ff.general_register[st_ff.idx[4:0]];
        OFF_FPRLO: nxt_st.rd = st_ff.floating_register[st_ff.idx[4:0]][31:0];
        OFF_FPRHI: nxt_st.rd = st_ff.floating_register[st_ff.idx[4:0]][63:32];
        OFF_CP0:   nxt_st.rd = st_ff.cp0[st_ff.idx[5:3]];
        OFF_STAT:  nxt_st.rd = {30'h0, st_ff.exc};
        default:   nxt_st.rd = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  assign rdData = st_ff.rd;
  assign trapPulse = st_ff.trap;
  assign trapCode = st_ff.exc;

  // ==========================================
  // Checks
  // Operand values one cycle back, for the checks only
  logic [31:0] rsvP;
  logic [31:0] rtvP;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) {rsvP, rtvP} <= '0;
    else {rsvP, rtvP} <= {st_ff.general_register[ins[25:21]], st_ff.general_register[ins[20:16]]};
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence seq_op(logic [5:0] o);
    iss && ins[31:26] == o;
  endsequence
  sequence seq_fn(logic [5:0] o, logic [5:0] f);
    seq_op(o) ##0 ins[5:0] == f;
  endsequence

  chk_move_if_zero_copy: assert property (seq_fn(OP_SPECIAL, FN_MOVE_IF_ZERO) ##0 // RULE1
      (st_ff.general_register[ins[20:16]] == 0 && ins[15:11] != 0) |=>
      st_ff.general_register[$past(ins[15:11])] == $past(st_ff.general_register[ins[25:21]]))
    else $error("move-if-zero did not copy");
  chk_move_if_zero_hold: assert property (seq_fn(OP_SPECIAL, FN_MOVE_IF_ZERO) ##0 // RULE1
      st_ff.general_register[ins[20:16]] != 0 |=> $stable(st_ff.general_register))
    else $error("move-if-zero changed registers");
  chk_fmovz_copy: assert property (seq_fn(OP_FLTCOP, FN_FMOVZ) ##0 // RULE2
      (st_ff.ctrl[CTL_CU1] && ins[25:21] == FMT_S &&
       st_ff.general_register[ins[20:16]] == 0) |=>
      st_ff.floating_register[$past(ins[10:6])] == $past(st_ff.floating_register[ins[15:11]]))
    else $error("float move-if-zero did not copy");
  chk_fmovz_keep: assert property (seq_fn(OP_FLTCOP, FN_FMOVZ) ##0 // RULE3
      st_ff.general_register[ins[20:16]] != 0 |=> $stable(st_ff.floating_register))
    else $error("float destination changed");
  chk_fmovz_quiet: assert property (seq_fn(OP_FLTCOP, FN_FMOVZ) |=> // RULE4
      $stable(st_ff.float_control_register) && trapCode != EXC_FPE)
    else $error("float move touched float status");
  chk_signed_mult_subtract_signed: assert property (seq_fn(OP_SECOND, FN_SIGNED_MULT_SUBTRACT) |=> // RULE10
      {st_ff.hi, st_ff.lo} == $past({st_ff.hi, st_ff.lo}) -
      ({{32{rsvP[31]}}, rsvP} * {{32{rtvP[31]}}, rtvP}))
    else $error("signed multiply-subtract wrong");
  chk_signed_mult_subtract_unsign: assert property (seq_fn(OP_SECOND, FN_UNSIGNED_MULT_SUBTRACT) |=> // RULE12
      {st_ff.hi, st_ff.lo} == $past({st_ff.hi, st_ff.lo}) -
      ({32'h0, rsvP} * {32'h0, rtvP}))
    else $error("unsigned multiply-subtract wrong");
  chk_signed_mult_subtract_nogpr: assert property (seq_op(OP_SECOND) ##0 // RULE11
      ins[5:1] == FN_SIGNED_MULT_SUBTRACT[5:1] |=> $stable(st_ff.general_register) && !trapPulse)
    else $error("multiply-subtract trapped or wrote");
  chk_move_to_system_cop_write: assert property (seq_op(OP_SYSCOP) ##0 // RULE19
      (st_ff.ctrl[CTL_CU0] && ins[25:21] == SUB_MT && ins[10:0] == 0 &&
       ins[15:14] == 0) |=> st_ff.cp0[$past(ins[13:11])] ==
      $past(st_ff.general_register[ins[20:16]]))
    else $error("system register not loaded");
  chk_cop_unusable: assert property (seq_op(OP_SYSCOP) ##0 // RULE22
      !st_ff.ctrl[CTL_CU0] |=> trapPulse && trapCode == EXC_CPU)
    else $error("missing unusable trap");
  chk_fpe_flags: assert property (seq_op(OP_FLTX) ##1 !trapPulse |-> // RULE17
      st_ff.float_control_register[FC_FLAG+:5] == ($past(st_ff.float_control_register[FC_FLAG+:5]) |
      st_ff.float_control_register[FC_CAUSE+:5]))
    else $error("flags not accumulated");
endmodule

// ---- logic/cms_pkg.sv ----
// What this block does
// RULE1 - Integer move-if-zero copies source into destination when test is zero
// RULE2 - Float move-if-zero copies float source to destination when test is zero
// RULE3 - Nonzero test leaves float destination holding its previous value
// RULE4 - Float move-if-zero is non-arithmetic and never raises IEEE flags
// RULE5 - Software avoids paired forms in sixteen float register mode
// RULE6 - Software names only float registers valid for the format
// RULE7 - Software supplies float operands already in the selected format
// RULE8 - Float move-if-zero may raise unusable or reserved-instruction traps
// RULE9 - Signed multiply-subtract forms a signed 64-bit product of two words
// RULE10 - Product is subtracted from high:low; halves go back high and low
// RULE11 - Integer multiply-subtract never traps and writes no general register
// RULE12 - Unsigned multiply-subtract treats both word operands as unsigned
// RULE13 - Software should put the shorter operand in the second source
// RULE14 - Float multiply-subtract stores source times second minus addend
// RULE15 - Product rounded, then difference rounded, like separate operations
// RULE16 - Paired form works per half and ORs both halves' conditions
// RULE17 - Without a trap, cause bits are ORed into the sticky flags
// RULE18 - Float multiply-subtract raises inexact, unimplemented, invalid, O, U; U is never raised here, tiny results raise unimplemented
// RULE19 - Move to system coprocessor loads register picked by number and select
// RULE20 - Software uses select zero for registers without selection
// RULE21 - Writes to absent system registers are simply dropped
// RULE22 - Move to system coprocessor may raise unusable or reserved traps
package cms_pkg;
  // ==========================================
  // Register map
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_CTRL  = 8'h04;
  localparam logic [7:0] OFF_FLOAT_CONTROL_REGISTER  = 8'h08;
  localparam logic [7:0] OFF_HI    = 8'h0C;
  localparam logic [7:0] OFF_LO    = 8'h10;
  localparam logic [7:0] OFF_INDEX = 8'h14;
  localparam logic [7:0] OFF_GPR   = 8'h18;
  localparam logic [7:0] OFF_FPRLO = 8'h1C;
  localparam logic [7:0] OFF_FPRHI = 8'h20;
  localparam logic [7:0] OFF_CP0   = 8'h24;
  localparam logic [7:0] OFF_STAT  = 8'h28;
  // Control bits
  localparam int CTL_CU0 = 0;
  localparam int CTL_CU1 = 1;
  localparam int CTL_FR16 = 2;
  // ==========================================
  // Opcodes
  localparam logic [5:0] OP_SPECIAL = 6'h00;
  localparam logic [5:0] OP_SECOND  = 6'h1C;
  localparam logic [5:0] OP_SYSCOP  = 6'h10;
  localparam logic [5:0] OP_FLTCOP  = 6'h11;
  localparam logic [5:0] OP_FLTX    = 6'h13;
  localparam logic [5:0] FN_MOVE_IF_ZERO    = 6'h0A;
  localparam logic [5:0] FN_FMOVZ   = 6'h12;
  localparam logic [5:0] FN_SIGNED_MULT_SUBTRACT    = 6'h04;
  localparam logic [5:0] FN_UNSIGNED_MULT_SUBTRACT   = 6'h05;
  localparam logic [4:0] SUB_MT     = 5'h04;
  localparam logic [2:0] FX_SIGNED_MULT_SUBTRACT    = 3'h5;
  localparam logic [4:0] FMT_S      = 5'h10;
  localparam logic [4:0] FMT_D      = 5'h11;
  localparam logic [4:0] FMT_PS     = 5'h16;
  localparam logic [2:0] XF_S       = 3'h0;
  localparam logic [2:0] XF_D       = 3'h1;
  localparam logic [2:0] XF_PS      = 3'h6;
  localparam logic [4:0] CP0_NUM    = 5'h08;
  // ==========================================
  // Float control register layout
  localparam int FC_W = 18;
  localparam int FC_FLAG = 2;
  localparam int FC_EN = 7;
  localparam int FC_CAUSE = 12;
  localparam logic [1:0] RM_NEAR = 2'h0;
  localparam logic [1:0] RM_ZERO = 2'h1;
  localparam logic [1:0] RM_PINF = 2'h2;
  localparam logic [1:0] RM_MINF = 2'h3;
  localparam logic [5:0] C_E = 6'h20;
  localparam logic [5:0] C_V = 6'h10;
  localparam logic [5:0] C_O = 6'h04;
  localparam logic [5:0] C_I = 6'h01;
  localparam logic [31:0] NAN_DEF = 32'h7FBF_FFFF;
  localparam logic [30:0] INF_MAG = 31'h7F80_0000;
  localparam logic [30:0] MAX_MAG = 31'h7F7F_FFFF;
  localparam logic signed [10:0] BIAS = 11'sh07F;
  localparam logic signed [10:0] EXP_INF = 11'sh0FF;
  typedef enum logic [1:0] {EXC_NONE, EXC_CPU, EXC_RI, EXC_FPE} cms_exc_e;
endpackage
